// ### hw/ebr_fabric_ctrl.sv
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "ebr_regs.svh"
module ebr_fabric_ctrl #(
  parameter int AW = `EBR_AW,
  parameter int DW = `EBR_DW
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  ebr_if.usr LNK
);
  import ebr_pkg::*;

  localparam int DEPTH = 1 << AW;

  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  logic [8:0] ctrl_r;
  logic [31:0] wdata_r [2];
  logic [DW-1:0] rdata_r [2];
  logic [25:0] shift_r;
  logic [2:0] cnt_r;
  ebr_port_t cap_r;
  logic refused_r;
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] qn_r;
  logic busy;
  logic go_a;
  logic go_b;
  logic go_q;
  logic go_clr;
  logic push;
  logic pop;
  logic q_empty;
  logic q_full;
  logic sr_ok;
  logic [31:0] stat;

  // shift register in one block: w*m*n and w*n limits
  function automatic logic sr_check(input logic [25:0] c);
    int w;
    int m;
    int n;
    w = int'(c[`EBR_SH_TLEN-1:0]);
    m = int'(c[`EBR_SH_TAPS-1:`EBR_SH_TLEN]);
    n = int'(c[25:`EBR_SH_TAPS]);
    return (w * m * n <= `EBR_BITS_MAX) && (w * n <= `EBR_SR_WMAX);
  endfunction

  // 36-bit word from the data register and the command's top nibble
  function automatic logic [DW-1:0] word(input logic [31:0] lo, input logic [31:0] cmd);
    return DW'({cmd[`EBR_CMD_HI+3:`EBR_CMD_HI], lo});
  endfunction

  // zero-wait slave; every transfer answers OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // address phase capture
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_wr_r <= HSEL && HTRANS[1] && HREADY && HWRITE;
      ap_addr_r <= HADDR[7:0];
    end
  end

  assign busy = cnt_r != 3'h0;
  assign q_empty = qn_r == '0;
  assign q_full = qn_r == (AW + 1)'(DEPTH);
  assign sr_ok = sr_check(shift_r);
  assign go_a = ap_wr_r && ap_addr_r == `EBR_OFS_CMD_A && !busy;
  assign go_b = ap_wr_r && ap_addr_r == `EBR_OFS_CMD_B && !busy;
  assign go_q = ap_wr_r && ap_addr_r == `EBR_OFS_QUEUE && !busy;
  // a clear is refused while busy, or it may spoil the read data
  assign go_clr = ap_wr_r && ap_addr_r == `EBR_OFS_CLR && !busy;
  assign push = go_q && HWDATA[0] && !q_full;
  // on an empty queue a pop never joins a push in one cycle
  assign pop = go_q && HWDATA[1] && !q_empty;
  assign stat = {19'h0, refused_r, q_full, q_empty, sr_ok, busy,
                 rdata_r[1][DW-1:32], rdata_r[0][DW-1:32]};

  // read data register, loaded in the address phase
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      HRDATA <= 32'h0;
    end else if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
      unique case (HADDR[7:0])
        `EBR_OFS_CTRL: HRDATA <= {23'h0, ctrl_r};
        `EBR_OFS_WDATA_A: HRDATA <= wdata_r[0];
        `EBR_OFS_WDATA_B: HRDATA <= wdata_r[1];
        `EBR_OFS_RDATA_A: HRDATA <= rdata_r[0][31:0];
        `EBR_OFS_RDATA_B: HRDATA <= rdata_r[1][31:0];
        `EBR_OFS_STAT: HRDATA <= stat;
        `EBR_OFS_SHIFT: HRDATA <= {6'h0, shift_r};
        `EBR_OFS_QUEUE: HRDATA <= 32'(qn_r);
        default: HRDATA <= 32'h0;
      endcase
    end
  end

  // configuration registers written by software
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= `EBR_CTRL_RST;
      wdata_r[0] <= 32'h0;
      wdata_r[1] <= 32'h0;
      shift_r <= 26'h0;
    end else if (ap_wr_r) begin
      if (ap_addr_r == `EBR_OFS_CTRL) ctrl_r <= HWDATA[8:0];
      if (ap_addr_r == `EBR_OFS_WDATA_A) wdata_r[0] <= HWDATA;
      if (ap_addr_r == `EBR_OFS_WDATA_B) wdata_r[1] <= HWDATA;
      if (ap_addr_r == `EBR_OFS_SHIFT) shift_r <= HWDATA[25:0];
    end
  end

  // an order while busy or a pop on an empty queue sets the flag (a push on a full queue does not); set beats a same-cycle clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      refused_r <= 1'b0;
    end else if (ap_wr_r && busy && (ap_addr_r == `EBR_OFS_CMD_A || ap_addr_r == `EBR_OFS_CMD_B ||
                 ap_addr_r == `EBR_OFS_QUEUE || ap_addr_r == `EBR_OFS_CLR)) begin
      refused_r <= 1'b1;
    end else if (go_q && HWDATA[1] && q_empty) begin
      refused_r <= 1'b1;
    end else if (ap_wr_r && ap_addr_r == `EBR_OFS_STAT && HWDATA[`EBR_ST_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  // one-cycle strobes to the block; read strobes only when reading
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LNK.we <= 2'b00;
      LNK.re <= 2'b00;
      LNK.addr <= '0;
      LNK.din <= '0;
      LNK.aclr <= 2'b00;
      LNK.dev_clr <= 1'b0;
    end else begin
      LNK.we <= 2'b00;
      LNK.re <= 2'b00;
      LNK.aclr <= go_clr ? HWDATA[1:0] : 2'b00;
      LNK.dev_clr <= go_clr && HWDATA[`EBR_CLR_DEV];
      if (go_a || push) begin
        LNK.addr[0] <= push ? wp_r : HWDATA[AW-1:0];
        LNK.din[0] <= push ? DW'(wdata_r[0]) : word(wdata_r[0], HWDATA);
        LNK.we[0] <= push || HWDATA[`EBR_CMD_WR];
        LNK.re[0] <= go_a && HWDATA[`EBR_CMD_RD];
      end
      if (go_b || pop) begin
        LNK.addr[1] <= pop ? rp_r : HWDATA[AW-1:0];
        LNK.din[1] <= word(wdata_r[1], HWDATA);
        LNK.we[1] <= go_b && HWDATA[`EBR_CMD_WR];
        LNK.re[1] <= pop || HWDATA[`EBR_CMD_RD];
      end
    end
  end

  // static controls; packed mode needs the single shared clock
  assign LNK.mode = ebr_mode_e'(ctrl_r[`EBR_CTRL_MODE+2:`EBR_CTRL_MODE]);
  assign LNK.ce = ctrl_r[`EBR_CTRL_CE+1:`EBR_CTRL_CE];
  assign LNK.hold = ctrl_r[`EBR_CTRL_HOLD+1:`EBR_CTRL_HOLD];
  assign LNK.oreg = ctrl_r[`EBR_CTRL_OREG+1:`EBR_CTRL_OREG];

  // read latency counter; assumes clock enables stay high while busy
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= 3'h0;
      cap_r <= 2'b00;
    end else if (go_a || go_b || push || pop || go_clr) begin
      cnt_r <= (|LNK.oreg) ? `EBR_LAT_OREG : `EBR_LAT_LATCH;
      cap_r <= {pop || (go_b && HWDATA[`EBR_CMD_RD]), go_a && HWDATA[`EBR_CMD_RD]};
    end else if (busy) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  // capture the answer of each port that read
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rdata_r[0] <= '0;
      rdata_r[1] <= '0;
    end else if (cnt_r == 3'h1) begin
      if (cap_r[0]) rdata_r[0] <= LNK.q[0];
      if (cap_r[1]) rdata_r[1] <= LNK.q[1];
    end
  end

  // queue pointers over the array: push on A, pop on B
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wp_r <= '0;
      rp_r <= '0;
      qn_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop) rp_r <= rp_r + AW'(1);
      qn_r <= qn_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// ### hw/ebr_ram_block.sv
`timescale 1ns/10ps
`include "ebr_regs.svh"
// Summary of operation
// - same-address read and write is read-during-write
// - packed halves: half capacity, 18 bits each
// - packed halves run on one clock
// - each port has own address hold
// - hold high keeps previous address register value
// - only read address register of the inputs clears on aclr
// - no read-address clear during a read
// - output register clear acts without clock
// - output latch clearable without output register
// - reset by power-up, clear, device-wide clear
// - all memory inputs are registered
// - single-port: read or write, one address
// - single-port read during write shows new data
// - write without read keeps last output
// - simple dual: write A, read B
// - read strobe low when not reading
// - true dual: any pair of operations
// - ROM address registered, output optionally registered
// - dual ROM adds second read address
// - ROM read equals RAM read, preloaded contents
// - shift register size and width limits
// - no same-cycle read and write when empty
// - clock enable low freezes the port
module ebr_ram_block #(
  parameter int AW = `EBR_AW,
  parameter int DW = `EBR_DW
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  ebr_if.dev LNK
);
  import ebr_pkg::*;

  localparam int DEPTH = 1 << AW;

  // storage; contents survive every clear, only registers are reset
  logic [DW-1:0] mem [DEPTH];

  // which ports may write in a given mode
  function automatic logic wr_ok(input logic p, input ebr_mode_e m);
    logic ok;
    ok = 1'b0;
    unique case (m)
      EBR_SP_RAM: ok = !p;
      EBR_SD_RAM: ok = !p;
      EBR_TD_RAM: ok = 1'b1;
      EBR_PACKED: ok = 1'b1;
      EBR_SP_ROM: ok = 1'b0;
      EBR_DP_ROM: ok = 1'b0;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // which ports may read in a given mode
  function automatic logic rd_ok(input logic p, input ebr_mode_e m);
    logic ok;
    ok = 1'b0;
    unique case (m)
      EBR_SP_RAM: ok = !p;
      EBR_SD_RAM: ok = p;
      EBR_TD_RAM: ok = 1'b1;
      EBR_PACKED: ok = 1'b1;
      EBR_SP_ROM: ok = !p;
      EBR_DP_ROM: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // packed mode gives each port its own half of the array
  function automatic logic [AW-1:0] eaddr(input logic p, input logic [AW-1:0] a, input ebr_mode_e m);
    logic [AW-1:0] r;
    r = a;
    if (m == EBR_PACKED) begin
      r = {p, a[AW-2:0]};
    end
    return r;
  endfunction

  // packed halves are at most 18 bits wide
  function automatic logic [DW-1:0] dmask(input logic [DW-1:0] d, input ebr_mode_e m);
    logic [DW-1:0] r;
    r = d;
    if (m == EBR_PACKED) begin
      r = {{(DW - `EBR_PACK_DW){1'b0}}, d[`EBR_PACK_DW-1:0]};
    end
    return r;
  endfunction

  // one clear rule for every register that aclr reaches
  function automatic logic port_clr(input logic rst, input logic dev, input logic aclr);
    return rst | dev | aclr;
  endfunction

  for (genvar gp = 0; gp < 2; gp++) begin : g_port
    localparam logic P = 1'(gp);
    logic clr_in;
    logic clr_rd;
    logic clr_out;
    logic ce;
    logic [AW-1:0] rd_addr_r;
    logic [AW-1:0] wr_addr_r;
    logic [DW-1:0] din_r;
    logic we_r;
    logic re_r;
    logic wr_go;
    logic rd_go;
    logic [DW-1:0] latch_r;
    logic [DW-1:0] oreg_r;
    logic [DW-1:0] q_p;
    logic addr_ld;
    logic rdw_hit;

    // clear sources; aclr and dev_clr come from flops of the user logic, RST from the reset input
    assign clr_in = RST | LNK.dev_clr;
    assign clr_rd = port_clr(RST, LNK.dev_clr, LNK.aclr[P]);
    assign clr_out = port_clr(RST, LNK.dev_clr, LNK.aclr[P]);
    assign ce = LNK.ce[P];

    // address load; a held port feeds its old address back
    assign addr_ld = ce && !LNK.hold[P];

    // read address register: the one input register that aclr clears
    always_ff @(posedge CORE_CLK or posedge clr_rd) begin
      if (clr_rd) begin
        rd_addr_r <= '0;
      end else if (addr_ld) begin
        rd_addr_r <= eaddr(P, LNK.addr[P], LNK.mode);
      end
    end

    // write address register: held by the same stall, never cleared by aclr
    always_ff @(posedge CORE_CLK or posedge clr_in) begin
      if (clr_in) begin
        wr_addr_r <= '0;
      end else if (addr_ld) begin
        wr_addr_r <= eaddr(P, LNK.addr[P], LNK.mode);
      end
    end

    // write data register; no aclr, so a port clear cannot spoil a write
    always_ff @(posedge CORE_CLK or posedge clr_in) begin
      if (clr_in) begin
        din_r <= '0;
      end else if (ce) begin
        din_r <= dmask(LNK.din[P], LNK.mode);
      end
    end

    // strobe registers; a strobe the mode refuses never reaches the array
    always_ff @(posedge CORE_CLK or posedge clr_in) begin
      if (clr_in) begin
        we_r <= 1'b0;
        re_r <= 1'b0;
      end else if (ce) begin
        we_r <= LNK.we[P] && wr_ok(P, LNK.mode);
        re_r <= LNK.re[P] && rd_ok(P, LNK.mode);
      end
    end

    // operations act only on enabled edges
    assign wr_go = ce && we_r;
    assign rd_go = ce && re_r;

    // same-port collision; a write on the other port lands after this read
    assign rdw_hit = wr_go && wr_addr_r == rd_addr_r;

    // output latch: same port shows the word being written (new data),
    // the other port reads the array before this edge's write (old data)
    always_ff @(posedge CORE_CLK or posedge clr_out) begin
      if (clr_out) begin
        latch_r <= '0;
      end else if (rd_go) begin
        if (rdw_hit) begin
          latch_r <= din_r;
        end else begin
          latch_r <= mem[rd_addr_r];
        end
      end
    end

    // optional output register, cleared at once by aclr
    always_ff @(posedge CORE_CLK or posedge clr_out) begin
      if (clr_out) begin
        oreg_r <= '0;
      end else if (ce) begin
        oreg_r <= latch_r;
      end
    end

    // registered or unregistered read data, both straight from flops
    assign q_p = LNK.oreg[P] ? oreg_r : latch_r;
  end

  // array writes; port B wins when both ports write one word
  always_ff @(posedge CORE_CLK) begin
    if (g_port[0].wr_go) begin
      mem[g_port[0].wr_addr_r] <= g_port[0].din_r;
    end
    if (g_port[1].wr_go) begin
      mem[g_port[1].wr_addr_r] <= g_port[1].din_r;
    end
  end

  // both ports' read data onto the link
  assign LNK.q = {g_port[1].q_p, g_port[0].q_p};
endmodule

// ### shared/ebr_if.sv
`timescale 1ns/10ps
`include "ebr_regs.svh"
interface ebr_if #(parameter int AW = `EBR_AW, parameter int DW = `EBR_DW);
  import ebr_pkg::*;
  ebr_mode_e mode;
  ebr_port_t ce;
  ebr_port_t hold;
  ebr_port_t oreg;
  ebr_port_t we;
  ebr_port_t re;
  ebr_port_t aclr;
  logic dev_clr;
  logic [1:0][AW-1:0] addr;
  logic [1:0][DW-1:0] din;
  logic [1:0][DW-1:0] q;
  modport dev (input mode, ce, hold, oreg, we, re, aclr, dev_clr, addr, din, output q);
  modport usr (output mode, ce, hold, oreg, we, re, aclr, dev_clr, addr, din, input q);
endinterface

// ### shared/ebr_pkg.sv
package ebr_pkg;
  // operating modes of the memory block; codes 6 and 7 are unused
  typedef enum logic [2:0] {
    EBR_SP_RAM,
    EBR_SD_RAM,
    EBR_TD_RAM,
    EBR_SP_ROM,
    EBR_DP_ROM,
    EBR_PACKED
  } ebr_mode_e;
  typedef logic [1:0] ebr_port_t;
endpackage

// ### shared/ebr_regs.svh
`ifndef EBR_REGS_SVH
`define EBR_REGS_SVH
// block geometry: 256 words of 36 bits
`define EBR_AW 8
`define EBR_DW 36
`define EBR_PACK_DW 18
`define EBR_BITS_MAX 9216
`define EBR_SR_WMAX 36
// controller register offsets (byte addresses)
`define EBR_OFS_CTRL 8'h00
`define EBR_OFS_CLR 8'h04
`define EBR_OFS_WDATA_A 8'h08
`define EBR_OFS_CMD_A 8'h0c
`define EBR_OFS_WDATA_B 8'h10
`define EBR_OFS_CMD_B 8'h14
`define EBR_OFS_RDATA_A 8'h18
`define EBR_OFS_RDATA_B 8'h1c
`define EBR_OFS_STAT 8'h20
`define EBR_OFS_SHIFT 8'h24
`define EBR_OFS_QUEUE 8'h28
// control fields
`define EBR_CTRL_MODE 0
`define EBR_CTRL_CE 3
`define EBR_CTRL_HOLD 5
`define EBR_CTRL_OREG 7
`define EBR_CTRL_RST 9'h018
// command fields
`define EBR_CMD_WR 8
`define EBR_CMD_RD 9
`define EBR_CMD_HI 12
// clear fields
`define EBR_CLR_DEV 2
// status fields
`define EBR_ST_BUSY 8
`define EBR_ST_SROK 9
`define EBR_ST_QEMPTY 10
`define EBR_ST_QFULL 11
`define EBR_ST_REFUSED 12
// shift-register check fields
`define EBR_SH_TLEN 6
`define EBR_SH_TAPS 20
// cycles from command strobe to captured read data
`define EBR_LAT_LATCH 3'h3
`define EBR_LAT_OREG 3'h4
`endif

// ### tb/ebr_asserts.sv
`timescale 1ns/10ps
module ebr_asserts #(parameter int DW = 36) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input ebr_pkg::ebr_port_t ce,
  input ebr_pkg::ebr_port_t hold,
  input ebr_pkg::ebr_port_t oreg,
  input ebr_pkg::ebr_port_t we,
  input ebr_pkg::ebr_port_t re,
  input ebr_pkg::ebr_port_t aclr,
  input wire logic dev_clr,
  input wire logic [1:0][DW-1:0] q
);
  import ebr_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // four quiet cycles on port a, so nothing may move its output
  sequence no_rd_s;
    !re[0] ##1 !re[0] ##1 !re[0] ##1 (!re[0] && !aclr[0] && !dev_clr && $stable(oreg[0]));
  endsequence
  // clears act without waiting for an edge
  oreg_clr_a: assert property (aclr[0] |-> q[0] == '0)
    else $error("port a output not cleared");
  latch_clr_a: assert property (aclr[1] && !oreg[1] |-> q[1] == '0)
    else $error("port b latch not cleared");
  dev_clr_a: assert property (dev_clr |-> q == '0)
    else $error("device clear left outputs set");
  q_keep_a: assert property (no_rd_s |-> $stable(q[0]))
    else $error("port a output moved without a read");
  ce_freeze_a: assert property (!ce[0] |=> aclr[0] || dev_clr || !$stable(oreg[0]) || $stable(q[0]))
    else $error("port a moved with clock enable low");
  // output changes only at the fixed read latency of the selected path
  q_lat_a: assert property ($changed(q[0]) && !aclr[0] && !dev_clr && $stable(oreg[0])
    |-> (oreg[0] ? $past(re[0], 3) : $past(re[0], 2)))
    else $error("port a output changed off read latency");
  clr_no_read_a: assert property (|aclr |-> re == '0 && $past(re) == '0)
    else $error("clear issued during a read");
  re_pulse_a: assert property (re[1] |=> !re[1])
    else $error("port b read strobe held high");
  cover property (aclr[0]);
  cover property (re[0] && we[0]);
  cover property (hold[0] && re[0]);
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import ebr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [31:0] rdat;
  logic [35:0] v;
  logic [31:0] sh [4] = '{32'h104024, 32'h204012, 32'h104064, 32'h200413};
  int err_count = 0;
  int n_tests = 0;
  ebr_if lnk ();
  always #10 clk = ~clk;
  // both ends face each other; the checker watches the link between them
  ebr_ram_block i_ebr_ram_block (.CORE_CLK(clk), .RST(rst), .LNK(lnk.dev));
  ebr_fabric_ctrl i_ebr_fabric_ctrl (.CORE_CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .LNK(lnk.usr));
  ebr_asserts #(.DW(36)) i_ebr_asserts (.CORE_CLK(clk), .RST(rst), .ce(lnk.ce), .hold(lnk.hold),
    .oreg(lnk.oreg), .we(lnk.we), .re(lnk.re), .aclr(lnk.aclr), .dev_clr(lnk.dev_clr), .q(lnk.q));
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // one single transfer; read data is taken at the edge closing the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  // one spare edge first, then poll the status register until busy reads low
  task automatic idle();
    int k;
    k = 0;
    @(posedge clk);
    do begin
      ahb(1'b0, 8'h20, 32'h0);
      k++;
    end while (rdat[8] !== 1'b0 && k < 50);
    if (rdat[8] !== 1'b0) begin
      err_count++;
      $display("MISMATCH busy exp 0 got %b", rdat[8]);
    end
  endtask
  task automatic cmd(input bit p, input logic w, input logic r, input logic [7:0] a, input logic [35:0] d);
    ahb(1'b1, p ? 8'h10 : 8'h08, d[31:0]);
    ahb(1'b1, p ? 8'h14 : 8'h0c, {16'h0, d[35:32], 2'h0, r, w, a});
    idle();
  endtask
  task automatic get(input bit p);
    ahb(1'b0, p ? 8'h1c : 8'h18, 32'h0);
    v[31:0] = rdat;
    ahb(1'b0, 8'h20, 32'h0);
    v[35:32] = p ? rdat[7:4] : rdat[3:0];
  endtask
  task automatic ctl(input ebr_mode_e m, input logic [1:0] h, input logic [1:0] o, input logic [1:0] c = 2'h3);
    ahb(1'b1, 8'h00, {23'h0, o, h, c, m});
  endtask
  function automatic logic [35:0] pat(input logic [7:0] a);
    return {a[3:0], 24'hc0ffee, a};
  endfunction
  // hang guard, far beyond the roughly 500 cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 36'h18, {4'h0, rdat});
    ahb(1'b1, 8'h30, 32'hffff_ffff);
    ahb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 36'h0, {3'h0, hresp, rdat});
    ctl(EBR_SP_RAM, 2'h0, 2'h0);
    for (int i = 0; i < 4; i++) cmd(0, 1, 0, 8'(i * 85), pat(8'(i * 85)));
    for (int i = 3; i >= 0; i--) begin
      cmd(0, 0, 1, 8'(i * 85), 36'h0);
      get(0);
      chk("sp read", pat(8'(i * 85)), v);
    end
    cmd(0, 1, 0, 8'h55, 36'h9_1234_5678);
    chk("q kept", pat(8'h00), lnk.q[0]);
    cmd(0, 1, 1, 8'haa, 36'ha_bcde_f012);
    get(0);
    chk("rdw new", 36'ha_bcde_f012, v);
    // clock enables off: the read must leave the output untouched
    ctl(EBR_SP_RAM, 2'h0, 2'h0, 2'h0);
    cmd(0, 0, 1, 8'h55, 36'h0);
    get(0);
    chk("ce low", 36'ha_bcde_f012, v);
    ctl(EBR_TD_RAM, 2'h0, 2'h0);
    cmd(0, 0, 1, 8'h55, 36'h0);
    get(0);
    chk("write landed", 36'h9_1234_5678, v);
    // hold on port a only; port b must still follow its address
    ctl(EBR_TD_RAM, 2'h1, 2'h0);
    cmd(0, 0, 1, 8'hff, 36'h0);
    get(0);
    chk("hold a", 36'h9_1234_5678, v);
    cmd(1, 0, 1, 8'hff, 36'h0);
    get(1);
    chk("free b", pat(8'hff), v);
    ctl(EBR_SD_RAM, 2'h0, 2'h0);
    cmd(0, 1, 0, 8'h10, pat(8'h10));
    cmd(1, 1, 0, 8'h10, 36'h0);
    cmd(0, 0, 1, 8'h10, 36'h0);
    cmd(1, 0, 1, 8'h10, 36'h0);
    get(1);
    chk("sd b read", pat(8'h10), v);
    get(0);
    chk("sd a refused", 36'h9_1234_5678, v);
    ctl(EBR_TD_RAM, 2'h0, 2'h0);
    cmd(1, 1, 0, 8'h20, pat(8'h20));
    // rom modes with latch and register outputs; writes must bounce
    for (int k = 0; k < 4; k++) begin
      ctl(k[0] ? EBR_DP_ROM : EBR_SP_ROM, 2'h0, k[1] ? 2'h3 : 2'h0);
      cmd(0, 1, 0, 8'h20, 36'h0);
      cmd(k[0], 0, 1, 8'h20, 36'h0);
      get(k[0]);
      chk("rom read", pat(8'h20), v);
    end
    ctl(EBR_PACKED, 2'h0, 2'h0);
    cmd(0, 1, 0, 8'h05, 36'h1_2345);
    cmd(1, 1, 0, 8'h05, 36'h7_ff02_abcd);
    for (int p = 0; p < 2; p++) begin
      cmd(p[0], 0, 1, 8'h05, 36'h0);
      get(p[0]);
      chk("packed", p ? 36'h2_abcd : 36'h1_2345, v);
    end
    // port a through its output register, port b through its latch
    ctl(EBR_TD_RAM, 2'h0, 2'h1);
    for (int i = 0; i < 3; i++) begin
      cmd(0, 0, 1, 8'h10, 36'h0);
      cmd(1, 0, 1, 8'h10, 36'h0);
      ahb(1'b1, 8'h04, 32'(1 << i));
      idle();
      chk("clear", 36'h0, i == 1 ? lnk.q[1] : lnk.q[0]);
    end
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 8'h24, sh[i]);
      idle();
      chk("shift ok", 36'(i < 2), {35'h0, rdat[9]});
    end
    // push and pop together on an empty queue: pop refused, push kept
    ctl(EBR_SD_RAM, 2'h0, 2'h0);
    ahb(1'b1, 8'h20, 32'h1000);
    ahb(1'b1, 8'h08, 32'h1111_2222);
    ahb(1'b1, 8'h28, 32'h3);
    idle();
    chk("pop refused", 36'h1, {35'h0, rdat[12]});
    ahb(1'b0, 8'h28, 32'h0);
    chk("count", 36'h1, {4'h0, rdat});
    ahb(1'b1, 8'h28, 32'h2);
    idle();
    chk("empty", 36'h1, {35'h0, rdat[10]});
    get(1);
    chk("pop", 36'h0_1111_2222, v);
    end_sim();
  end
endmodule
